// file: rtl/ppm_pkg.sv
// Package with the constants and carrier types of the pixel port select and mask block.
package ppm_pkg;
	localparam int PIX_W = 64;
	localparam int LEG_W = 8;
	localparam int PORT_SEL_BIT = 0;
	localparam int MASK_EN_BIT = 6;
	localparam int CLK_SRC_LSB = 6;
	localparam int PLL_RSVD_BIT = 4;
	localparam logic [1:0] CLK_SRC_REF = 2'h2;
	localparam logic [7:0] MISC1_RESET = 8'h00;
	localparam logic [7:0] MISC2_RESET = 8'h00;
	localparam logic [2:0] FMT_4BPP = 3'h2;
	localparam logic [2:0] FMT_32BPP = 3'h6;
	localparam int SCLK_DIV = 4;
	localparam int FIFO_DEPTH = 8;
	localparam logic [LEG_W-1:0] LEG_ZERO = 8'h00;
	typedef struct packed {
		logic [PIX_W-1:0] data;
		logic valid;
	} ppm_word_t;
	typedef struct packed {
		logic [1:0] clk_src;
		logic port_wide;
		logic mask_en;
	} ppm_ctrl_t;
endpackage

// file: rtl/ppm_top.sv
// Pixel port selection, wide-port latching and masking, with its word FIFO.
`timescale 1ns/1ps
module ppm_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 8
) (
	input wire logic mclk, // System clock.
	input wire logic reset, // Asynchronous reset.
	input wire logic in_valid, // Word offered.
	output logic in_ready, // Room for a word.
	input wire logic [WIDTH-1:0] in_data, // Word in.
	output logic out_valid, // Word available.
	input wire logic out_ready, // Drain accepts.
	output logic [WIDTH-1:0] out_data // Word out.
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic push, pop;
	// Handshake terms and pointer updates.
	always_comb begin
		push = in_valid && (count != FULL);
		pop = out_valid && out_ready;
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end
	// Registers pointers and the count.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end
	// Storage has no reset; a slot is only read after it has been written.
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
	assign in_ready = (count != FULL);
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
endmodule

module ppm_top
	import ppm_pkg::*;
#(
	parameter int WIDTH = PIX_W
) (
	input wire logic mclk, // 50 MHz system clock.
	input wire logic reset, // Asynchronous active-high reset.
	input wire logic load_clock_in, // Load clock pin from the controller.
	input wire logic [WIDTH-1:0] wide_pixel_bus, // Wide pixel pins.
	input wire logic [LEG_W-1:0] legacy_pixel, // Legacy 8-bit pixel pins.
	input wire logic [7:0] misc_ctrl1, // First misc control byte.
	input wire logic [7:0] misc_ctrl2, // Second misc control byte.
	input wire logic [2:0] pixel_format, // Pixel format code.
	input wire logic [WIDTH-1:0] wide_mask, // Mask high and low registers.
	input wire logic [7:0] pll_ctrl1, // First pll control byte.
	output logic shift_clock, // Serial clock to the controller.
	output logic [LEG_W-1:0] pixel_out, // Selected pixel byte.
	output logic [WIDTH-1:0] wide_latched, // Internal wide latch contents.
	output logic pixclk_is_ref, // Pixel clock from reference clock.
	output logic capture_ovf // Captured word dropped, FIFO full.
);
	logic lck_s1, lck_s2, lck_s3;
	logic [WIDTH-1:0] pix_s1, pix_s2;
	logic [$clog2(SCLK_DIV)-1:0] div, next_div;
	logic fmt_ok, sclk_tick, next_shift_clock;
	logic cap_valid, cap_ready, drain_valid;
	logic [WIDTH-1:0] drain_data, next_wide_latched, rcv;
	logic [LEG_W-1:0] next_pixel_out;
	logic next_pixclk_is_ref, next_capture_ovf;
	ppm_ctrl_t ctrl;
	// Control bits; pll bit 4 is reserved and deliberately unread.
	always_comb begin
		ctrl.port_wide = misc_ctrl2[PORT_SEL_BIT];
		ctrl.mask_en = misc_ctrl1[MASK_EN_BIT];
		ctrl.clk_src = misc_ctrl2[CLK_SRC_LSB +: 2];
	end
	// Two-stage synchronisers for the load clock and the wide pins.
	// The pins stand still well around a load clock rise, so the word arrives whole.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			lck_s1 <= 1'b0;
			lck_s2 <= 1'b0;
			lck_s3 <= 1'b0;
			pix_s1 <= '0;
			pix_s2 <= '0;
		end else begin
			lck_s1 <= load_clock_in;
			lck_s2 <= lck_s1;
			lck_s3 <= lck_s2;
			pix_s1 <= wide_pixel_bus;
			pix_s2 <= pix_s1;
		end
	end
	// Mask zeroes received bits only while enabled.
	always_comb begin
		rcv = ctrl.mask_en ? (pix_s2 & ~wide_mask) : pix_s2;
		cap_valid = lck_s2 && !lck_s3;
		fmt_ok = (pixel_format >= FMT_4BPP) && (pixel_format <= FMT_32BPP);
	end
	ppm_fifo #(.WIDTH(WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.mclk(mclk),
		.reset(reset),
		.in_valid(cap_valid),
		.in_ready(cap_ready),
		.in_data(rcv),
		.out_valid(drain_valid),
		.out_ready(sclk_tick),
		.out_data(drain_data)
	);
	// Shift clock divider, stopped for invalid formats or legacy port.
	// When stopped the divider freezes rather than clears, so its phase resumes.
	always_comb begin
		sclk_tick = 1'b0;
		next_div = div;
		next_shift_clock = 1'b0;
		if (fmt_ok && ctrl.port_wide) begin
			next_div = div + 1'b1;
			next_shift_clock = div[$clog2(SCLK_DIV)-1];
			sclk_tick = (div == '1);
		end
		// Relatch only at divider count 3, between the shift clock's rise and fall; otherwise hold the last value.
		next_wide_latched = (sclk_tick && drain_valid) ? drain_data : wide_latched;
		// Legacy path carries the OR flaw with the latched low byte.
		next_pixel_out = ctrl.port_wide ? wide_latched[LEG_W-1:0]
			: (legacy_pixel | wide_latched[LEG_W-1:0]);
		// Clock source decode and the dropped-capture pulse.
		next_pixclk_is_ref = (ctrl.clk_src == CLK_SRC_REF);
		next_capture_ovf = cap_valid && !cap_ready;
	end
	// Output and state registers; reset leaves a legacy-ready state.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			div <= '0;
			shift_clock <= 1'b0;
			wide_latched <= '0;
			pixel_out <= LEG_ZERO;
			pixclk_is_ref <= 1'b0;
			capture_ovf <= 1'b0;
		end else begin
			div <= next_div;
			shift_clock <= next_shift_clock;
			wide_latched <= next_wide_latched;
			pixel_out <= next_pixel_out;
			pixclk_is_ref <= next_pixclk_is_ref;
			capture_ovf <= next_capture_ovf;
		end
	end

	// Checks on the latch, the port selection, the mask and the clock source.
	property p_latch_hold;
		@(posedge mclk) disable iff (reset)
		!$past(sclk_tick) |-> $stable(wide_latched);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch moved without shift clock");
	property p_stop;
		@(posedge mclk) disable iff (reset)
		!fmt_ok |=> !shift_clock;
	endproperty
	a_stop: assert property (p_stop) else $error("shift clock ran with bad format");
	property p_or;
		@(posedge mclk) disable iff (reset)
		!ctrl.port_wide |=> pixel_out == ($past(legacy_pixel) | $past(wide_latched[LEG_W-1:0]));
	endproperty
	a_or: assert property (p_or) else $error("legacy pixel not merged");
	property p_wide;
		@(posedge mclk) disable iff (reset)
		ctrl.port_wide |=> pixel_out == $past(wide_latched[LEG_W-1:0]);
	endproperty
	a_wide: assert property (p_wide) else $error("wide pixel wrong");
	property p_hold_legacy;
		@(posedge mclk) disable iff (reset)
		!ctrl.port_wide ##1 !ctrl.port_wide |-> $stable(wide_latched);
	endproperty
	a_hold_legacy: assert property (p_hold_legacy) else $error("latch changed in legacy");
	property p_mask;
		@(posedge mclk) disable iff (reset)
		ctrl.mask_en |-> (rcv & wide_mask) == '0;
	endproperty
	a_mask: assert property (p_mask) else $error("masked bit passed");
	property p_nomask;
		@(posedge mclk) disable iff (reset)
		!ctrl.mask_en |-> rcv == pix_s2;
	endproperty
	a_nomask: assert property (p_nomask) else $error("mask applied while off");
	property p_src;
		@(posedge mclk) disable iff (reset)
		ctrl.clk_src == CLK_SRC_REF |=> pixclk_is_ref;
	endproperty
	a_src: assert property (p_src) else $error("reference source not chosen");
	property p_rst;
		@(posedge mclk) $fell(reset) |-> wide_latched == '0;
	endproperty
	a_rst: assert property (p_rst) else $error("latch not cleared");
	c_relatch: cover property (@(posedge mclk) disable iff (reset) sclk_tick && drain_valid);
	c_legacy_or: cover property (@(posedge mclk) disable iff (reset)
		!ctrl.port_wide && wide_latched[LEG_W-1:0] != LEG_ZERO);
	c_masked: cover property (@(posedge mclk) disable iff (reset) ctrl.mask_en && cap_valid);
	c_ovf: cover property (@(posedge mclk) disable iff (reset) capture_ovf);
	c_workaround: cover property (@(posedge mclk) disable iff (reset)
		!ctrl.port_wide && ctrl.mask_en && wide_latched[LEG_W-1:0] == LEG_ZERO);
	property p_relatch;
		@(posedge mclk) disable iff (reset)
		sclk_tick && drain_valid |=> wide_latched == $past(drain_data);
	endproperty
	a_relatch: assert property (p_relatch) else $error("relatch missed the drained word");
	property p_legacy_stop;
		@(posedge mclk) disable iff (reset)
		!ctrl.port_wide |=> !shift_clock;
	endproperty
	a_legacy_stop: assert property (p_legacy_stop) else $error("shift clock ran on legacy port");
endmodule

// file: verif/ppm_gfx_ctrl.sv
// Graphics controller model that drives the wide pixel bus and the load clock.
`timescale 1ns/1ps
module ppm_gfx_ctrl
	import ppm_pkg::*;
(
	output logic load_clock_in, // Load clock to the block.
	output logic [PIX_W-1:0] wide_pixel_bus // Pixel word to the block.
);
	// The load clock stands low between frames.
	initial begin
		load_clock_in = 1'b0;
		wide_pixel_bus = '0;
	end
	// One word per 160 ns load clock; the released bus shows the inverse value.
	task automatic send(input logic [PIX_W-1:0] w);
		wide_pixel_bus = w;
		#80 load_clock_in = 1'b1;
		#80 load_clock_in = 1'b0;
		wide_pixel_bus = ~w;
	endtask
endmodule

// file: verif/ppm_top_tb.sv
// Self-checking bench for the pixel port select and mask block.
`timescale 1ns/1ps
module ppm_top_tb;
	import ppm_pkg::*;
	logic mclk = 1'b0, reset = 1'b1, load_clock_in, shift_clock, pixclk_is_ref, capture_ovf;
	logic [PIX_W-1:0] wide_pixel_bus, wide_latched, wide_mask = '0, last = '0, prev = '0;
	logic [7:0] legacy_pixel = 8'h00, misc_ctrl1 = 8'h00, misc_ctrl2 = 8'h00, pll_ctrl1, pixel_out;
	logic [2:0] pixel_format = 3'h0;
	logic [PIX_W-1:0] exp_q[$];
	int mismatches = 0, tests_run = 0, seed = 32'h7168, rises = 0, ovf = 0;
	ppm_gfx_ctrl i_gc (.load_clock_in(load_clock_in), .wide_pixel_bus(wide_pixel_bus));
	ppm_top i_dut (.mclk(mclk), .reset(reset), .load_clock_in(load_clock_in),
		.wide_pixel_bus(wide_pixel_bus), .legacy_pixel(legacy_pixel), .misc_ctrl1(misc_ctrl1),
		.misc_ctrl2(misc_ctrl2), .pixel_format(pixel_format), .wide_mask(wide_mask),
		.pll_ctrl1(pll_ctrl1), .shift_clock(shift_clock), .pixel_out(pixel_out),
		.wide_latched(wide_latched), .pixclk_is_ref(pixclk_is_ref), .capture_ovf(capture_ovf));
	// Clock and event counters.
	always #10 mclk = ~mclk;
	always @(posedge shift_clock) rises++;
	always @(posedge mclk) if (capture_ovf === 1'b1) ovf++;
	task automatic bad(input string s);
		mismatches++;
		$display("unexpected at %0t: %s", $time, s);
	endtask
	task automatic cmp_word(input logic [PIX_W-1:0] g, e);
		tests_run++;
		if (g !== e) bad($sformatf("word %h want %h", g, e));
	endtask
	task automatic cmp_byte(input logic [7:0] g, e);
		tests_run++;
		if (g !== e) bad($sformatf("byte %h want %h", g, e));
	endtask
	task automatic cmp_cnt(input int g, e);
		tests_run++;
		if (g != e) bad($sformatf("count %0d want %0d", g, e));
	endtask
	task automatic final_report();
		$display("mismatches %0d, tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Notes the masked word it expects, then has the controller send it.
	task automatic put(input logic [PIX_W-1:0] w, input bit keep);
		if (keep) exp_q.push_back(w & ~(misc_ctrl1[6] ? wide_mask : '0));
		if (keep) last = exp_q[$];
		i_gc.send(w);
		#100;
	endtask
	// Counts shift clock rises over 40 system cycles.
	task automatic sclk(input int e);
		rises = 0;
		repeat (40) @(posedge mclk);
		#1 cmp_cnt(rises, e);
	endtask
	// Each change of the latch takes the oldest note off the queue, or the old value if none is left, and compares.
	always @(posedge mclk) begin
		#2;
		if (reset) prev = '0;
		else if (wide_latched !== prev) begin
			if (exp_q.size() == 0) cmp_word(wide_latched, prev);
			else cmp_word(wide_latched, exp_q.pop_front());
			prev = wide_latched;
		end
	end
	// Watchdog.
	initial begin
		#300000 mismatches++;
		final_report();
	end
	// Main sequence.
	initial begin
		pll_ctrl1 = 8'($random(seed));
		repeat (12) @(posedge mclk);
		#1 reset = 1'b0;
		legacy_pixel = 8'($random(seed));
		repeat (3) @(posedge mclk);
		#1 cmp_word(wide_latched, '0);
		cmp_byte(pixel_out, legacy_pixel);
		for (int c = 0; c < 4; c++) begin
			misc_ctrl2 = {c[1:0], 6'h00};
			pll_ctrl1 = pll_ctrl1 ^ 8'h10;
			repeat (3) @(posedge mclk);
			#1 cmp_byte({7'h00, pixclk_is_ref}, {7'h00, c == 2});
		end
		misc_ctrl2 = 8'h01;
		pixel_format = 3'h7;
		wide_mask = {$random(seed), $random(seed)};
		sclk(0);
		for (int i = 0; i < 9; i++) begin
			misc_ctrl1 = {1'b0, i[0], 6'h00};
			put({$random(seed), $random(seed)}, i < 8);
		end
		cmp_cnt(ovf, 1);
		for (int f = 2; f < 7; f++) begin
			pixel_format = f[2:0];
			sclk(10);
		end
		cmp_cnt(exp_q.size(), 0);
		cmp_byte(pixel_out, last[7:0]);
		misc_ctrl2 = 8'h00;
		sclk(0);
		cmp_byte(pixel_out, legacy_pixel | last[7:0]);
		// Software workaround, then the return to the wide port.
		misc_ctrl2 = 8'h01;
		wide_mask = 64'hff;
		misc_ctrl1 = 8'h40;
		put({$random(seed), $random(seed)}, 1);
		misc_ctrl2 = 8'h00;
		repeat (4) @(posedge mclk);
		#1 cmp_byte(pixel_out, legacy_pixel);
		misc_ctrl1 = 8'h00;
		misc_ctrl2 = 8'h01;
		put({$random(seed), $random(seed)}, 1);
		repeat (10) @(posedge mclk);
		#1 cmp_cnt(exp_q.size(), 0);
		// A second reset in mid-run must clear a latch that holds data.
		reset = 1'b1;
		repeat (2) @(posedge mclk);
		#1 reset = 1'b0;
		repeat (2) @(posedge mclk);
		#1 cmp_word(wide_latched, '0);
		cmp_byte(pixel_out, LEG_ZERO);
		final_report();
	end
endmodule
